// ===== tchp_pkg.sv
// Package for the timer-core host port: map, widths and states
package tchp_pkg;
   localparam int unsigned ADDR_W = 7;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned TIMER_SPACE = 128;
   localparam int unsigned DSP_SPACE = 4;
   // Byte offsets of the timer-core registers (high byte at the even address, except the little-endian window registers)
   localparam logic [6:0] OFS_MODE0 = 7'h00;
   localparam logic [6:0] OFS_MODE1 = 7'h02;
   localparam logic [6:0] OFS_RXWIN0 = 7'h04;
   localparam logic [6:0] OFS_RXWIN1 = 7'h05;
   localparam logic [6:0] OFS_RXWIN2 = 7'h06;
   localparam logic [6:0] OFS_TXWIN0 = 7'h07;
   localparam logic [6:0] OFS_TXWIN1 = 7'h08;
   localparam logic [6:0] OFS_RXSTART = 7'h09;
   localparam logic [6:0] OFS_TXSTART = 7'h0a;
   localparam logic [6:0] OFS_MONSTART = 7'h0c;
   localparam logic [6:0] OFS_TX_KEY_LINE_0 = 7'h0e;
   localparam logic [6:0] OFS_TX_KEY_LINE_1 = 7'h10;
   localparam logic [6:0] OFS_PWRON1 = 7'h12;
   // Reset values
   localparam logic [13:0] MODE_RESET = 14'h0000;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   // Cycles the device waits before acknowledging a DSP-core access
   localparam logic [1:0] DSP_ACK_DELAY = 2'h1;
   // Host controller APB register offsets
   localparam logic [7:0] APB_CTRL = 8'h00;
   localparam logic [7:0] APB_STATUS = 8'h04;
   localparam logic [7:0] APB_RDATA = 8'h08;
   // Host controller CTRL fields
   localparam int unsigned CTRL_GO = 0;
   localparam int unsigned CTRL_RNW = 1;
   localparam int unsigned CTRL_DSP = 2;
   localparam int unsigned CTRL_ADDR_LSB = 8;
   localparam int unsigned CTRL_DATA_LSB = 16;
   localparam logic [7:0] TIMER_READ_WAIT = 8'h03;
   typedef enum logic [3:0] {
      HC_IDLE = 4'b0001,
      HC_SETUP = 4'b0010,
      HC_WAIT = 4'b0100,
      HC_DONE = 4'b1000
   } tchp_hstate_type;
endpackage : tchp_pkg

// ===== tchp_if.sv
// Interface carrying the parallel host port between host and device
`timescale 1ns/1ps
`default_nettype none
interface tchp_if;
   logic [6:0] host_addr_bus;
   logic [7:0] host_data_out;      // Host drive of the data bus
   logic host_data_oe_n;           // Low while host drives
   logic [7:0] dev_data_out;       // Device drive of the data bus
   logic dev_data_oe_n;            // Low while device drives
   logic host_read_not_write;
   logic timer_core_select_n;
   logic dsp_core_select_n;
   logic transfer_ack_out_n;       // Device drive of the acknowledge
   logic transfer_ack_oe_n;        // Low while the device drives the acknowledge
   modport device (
      input host_addr_bus, host_data_out, host_data_oe_n, host_read_not_write,
      input timer_core_select_n, dsp_core_select_n,
      output dev_data_out, dev_data_oe_n, transfer_ack_out_n, transfer_ack_oe_n
   );
   modport host (
      output host_addr_bus, host_data_out, host_data_oe_n, host_read_not_write,
      output timer_core_select_n, dsp_core_select_n,
      input dev_data_out, dev_data_oe_n, transfer_ack_out_n, transfer_ack_oe_n
   );
endinterface : tchp_if
`default_nettype wire

// ===== tchp_device.sv
// Device end: timer-core register space and DSP-core port
// Operation
// - 128-byte timer space decoded only under select
// - 4-byte DSP space under its select
// - DSP decode uses only two address lines
// - No acknowledge for timer-core accesses
// - Acknowledge goes to host, host waits
// - Wide registers big-endian on even addresses, except the window registers, little-endian from 04 and 07
// - Three-byte receive window on 04-06, not padded to longword
// - Reserved, write-only bits read zero, ignore writes
// - Read/write line low writes, high reads
// - 8-bit data bus, 7-bit host address
// - Active-low selects, one at a time
// - Two 14-bit read/write mode registers
// - 7-bit receive burst start
// - 11-bit transmit burst start
// - 13-bit monitor burst start
// - 6-bit power-on lead in frames
`timescale 1ns/1ps
`default_nettype none
module tchp_device (
   input wire logic pclk,
   input wire logic presetn,
   tchp_if.device port,
   output logic [13:0] mode_control_0,
   output logic [13:0] mode_control_1,
   output logic [23:0] rx_window_len,
   output logic [15:0] tx_window_len,
   output logic [6:0] rx_burst_start,
   output logic [10:0] tx_burst_start,
   output logic [12:0] monitor_burst_start,
   output logic [9:0] tx_key_len_0,
   output logic [9:0] tx_key_len_1,
   output logic [5:0] power_on_1_lead,
   output logic [31:0] dsp_regs,
   output logic dsp_write_strobe
);
   import tchp_pkg::*;

   typedef struct packed {
      logic [13:0] mode0;
      logic [13:0] mode1;
      logic [2:0][7:0] rxwin;
      logic [1:0][7:0] txwin;
      logic [6:0] rxstart;
      logic [10:0] txstart;
      logic [12:0] monstart;
      logic [9:0] key0;
      logic [9:0] key1;
      logic [5:0] pwron1;
      logic [3:0][7:0] dsp;
      logic [7:0] dout;
      logic dout_oe_n;
      logic ack_n;
      logic ack_oe_n;
      logic [1:0] ack_cnt;
      logic acc_done;      // Current select cycle already handled
      logic dsp_wstb;
   } tchp_dev_state_type;

   tchp_dev_state_type state_reg, state_next;
   logic tsel;
   logic dsel;
   logic [7:0] wd;
   logic [6:0] a;
   logic [1:0] da;
   logic timer_wr;
   logic timer_rd;
   logic dsp_wr;
   logic dsp_rd;

   assign tsel = !port.timer_core_select_n;
   assign dsel = !port.dsp_core_select_n && port.timer_core_select_n;
   assign wd = port.host_data_out;
   assign a = port.host_addr_bus;
   assign da = port.host_addr_bus[1:0];

   // Access kinds; a write also needs the host to drive the data bus
   assign timer_wr = tsel && !port.host_read_not_write && !port.host_data_oe_n;
   assign timer_rd = tsel && port.host_read_not_write;
   assign dsp_wr = dsel && !port.host_read_not_write && !port.host_data_oe_n;
   assign dsp_rd = dsel && port.host_read_not_write;

   // Read multiplexer for the timer space
   function automatic logic [7:0] timer_read(input tchp_dev_state_type s, input logic [6:0] ad);
      logic [7:0] r;
      r = 8'h00;
      unique case (ad)
         OFS_MODE0: r = {2'b00, s.mode0[13:8]};
         OFS_MODE0 + 7'h01: r = s.mode0[7:0];
         OFS_MODE1: r = {2'b00, s.mode1[13:8]};
         OFS_MODE1 + 7'h01: r = s.mode1[7:0];
         OFS_RXWIN0, OFS_RXWIN1, OFS_RXWIN2: r = 8'h00; // Write-only
         OFS_TXWIN0, OFS_TXWIN1, OFS_RXSTART: r = 8'h00; // Write-only
         default: r = 8'h00;
      endcase
      return r;
   endfunction : timer_read

   // Next-state logic for both register spaces
   always_comb begin
      state_next = state_reg;
      state_next.dsp_wstb = 1'b0;
      if (!tsel && !dsel) begin
         state_next.acc_done = 1'b0;
         state_next.dout_oe_n = 1'b1;
         state_next.ack_n = 1'b1;
         state_next.ack_oe_n = 1'b1;
         state_next.ack_cnt = 2'h0;
      end else if (tsel) begin
         state_next.ack_oe_n = 1'b1;
         state_next.ack_n = 1'b1;
         // Device drives data only for a read
         state_next.dout_oe_n = !timer_rd;
         if (timer_rd) begin
            state_next.dout = timer_read(state_reg, a);
         end
         if (timer_wr) begin
            // Each byte lands on its own write; no staging
            unique case (a)
               OFS_MODE0: state_next.mode0[13:8] = wd[5:0];
               OFS_MODE0 + 7'h01: state_next.mode0[7:0] = wd;
               OFS_MODE1: state_next.mode1[13:8] = wd[5:0];
               OFS_MODE1 + 7'h01: state_next.mode1[7:0] = wd;
               OFS_RXWIN0: state_next.rxwin[0] = wd;
               OFS_RXWIN1: state_next.rxwin[1] = wd;
               OFS_RXWIN2: state_next.rxwin[2] = wd;
               OFS_TXWIN0: state_next.txwin[0] = wd;
               OFS_TXWIN1: state_next.txwin[1] = wd;
               OFS_RXSTART: state_next.rxstart = wd[6:0];
               OFS_TXSTART: state_next.txstart[10:8] = wd[2:0];
               OFS_TXSTART + 7'h01: state_next.txstart[7:0] = wd;
               OFS_MONSTART: state_next.monstart[12:8] = wd[4:0];
               OFS_MONSTART + 7'h01: state_next.monstart[7:0] = wd;
               OFS_TX_KEY_LINE_0: state_next.key0[9:8] = wd[1:0];
               OFS_TX_KEY_LINE_0 + 7'h01: state_next.key0[7:0] = wd;
               OFS_TX_KEY_LINE_1: state_next.key1[9:8] = wd[1:0];
               OFS_TX_KEY_LINE_1 + 7'h01: state_next.key1[7:0] = wd;
               OFS_PWRON1: state_next.pwron1 = wd[5:0];
               default: state_next.mode0 = state_reg.mode0;
            endcase
         end
      end else begin
         // DSP-core access: acknowledge after a short delay
         state_next.ack_oe_n = 1'b0;
         state_next.dout_oe_n = !dsp_rd;
         if (dsp_rd) begin
            state_next.dout = state_reg.dsp[da];
         end
         if (!state_reg.acc_done) begin
            if (state_reg.ack_cnt == DSP_ACK_DELAY) begin
               state_next.acc_done = 1'b1;
               state_next.ack_n = 1'b0;
               if (dsp_wr) begin
                  state_next.dsp[da] = wd;
                  state_next.dsp_wstb = 1'b1;
               end
            end else begin
               state_next.ack_cnt = state_reg.ack_cnt + 2'h1;
            end
         end
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= '0;
         state_reg.mode0 <= MODE_RESET;
         state_reg.mode1 <= MODE_RESET;
         // Write-only bytes and the DSP bytes come up cleared
         state_reg.rxwin <= {3{BYTE_RESET}};
         state_reg.txwin <= {2{BYTE_RESET}};
         state_reg.rxstart <= BYTE_RESET[6:0];
         state_reg.txstart <= {BYTE_RESET[2:0], BYTE_RESET};
         state_reg.monstart <= {BYTE_RESET[4:0], BYTE_RESET};
         state_reg.key0 <= {BYTE_RESET[1:0], BYTE_RESET};
         state_reg.key1 <= {BYTE_RESET[1:0], BYTE_RESET};
         state_reg.pwron1 <= BYTE_RESET[5:0];
         state_reg.dsp <= {4{BYTE_RESET}};
         state_reg.dout_oe_n <= 1'b1;
         state_reg.ack_n <= 1'b1;
         state_reg.ack_oe_n <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from the state register
   assign port.dev_data_out = state_reg.dout;
   assign port.dev_data_oe_n = state_reg.dout_oe_n;
   assign port.transfer_ack_out_n = state_reg.ack_n;
   assign port.transfer_ack_oe_n = state_reg.ack_oe_n;
   assign mode_control_0 = state_reg.mode0;
   assign mode_control_1 = state_reg.mode1;
   assign rx_window_len = state_reg.rxwin;
   assign tx_window_len = state_reg.txwin;
   assign rx_burst_start = state_reg.rxstart;
   assign tx_burst_start = state_reg.txstart;
   assign monitor_burst_start = state_reg.monstart;
   assign tx_key_len_0 = state_reg.key0;
   assign tx_key_len_1 = state_reg.key1;
   assign power_on_1_lead = state_reg.pwron1;
   assign dsp_regs = state_reg.dsp;
   assign dsp_write_strobe = state_reg.dsp_wstb;
endmodule : tchp_device
`default_nettype wire

// ===== tchp_host.sv
// Host end: APB-programmed controller driving the parallel host port
`timescale 1ns/1ps
`default_nettype none
module tchp_host (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   tchp_if.host port
);
   import tchp_pkg::*;

   typedef struct packed {
      tchp_hstate_type st;
      logic [6:0] addr;
      logic [7:0] wdata;
      logic [7:0] rdata;
      logic rnw;
      logic dsp;
      logic tsel_n;
      logic dsel_n;
      logic oe_n;
      logic [7:0] wait_cnt;
      logic done;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } tchp_host_state_type;

   tchp_host_state_type state_reg, state_next;
   logic setup_ph;
   logic ack_seen;

   assign setup_ph = psel && !penable;
   assign ack_seen = !port.transfer_ack_oe_n && !port.transfer_ack_out_n;

   // Controller and APB slave next state
   always_comb begin
      state_next = state_reg;
      state_next.pready = 1'b0;
      state_next.pslverr = 1'b0;
      if (setup_ph && !state_reg.pready) begin
         state_next.pready = 1'b1;
         state_next.prdata = 32'h0000_0000;
         if (pwrite) begin
            if (paddr == APB_CTRL && state_reg.st == HC_IDLE && pwdata[CTRL_GO]) begin
               state_next.rnw = pwdata[CTRL_RNW];
               state_next.dsp = pwdata[CTRL_DSP];
               state_next.addr = pwdata[CTRL_ADDR_LSB +: 7];
               state_next.wdata = pwdata[CTRL_DATA_LSB +: 8];
               state_next.done = 1'b0;
               state_next.st = HC_SETUP;
            end else if (paddr != APB_CTRL) begin
               state_next.pslverr = 1'b1;
            end
         end else begin
            unique case (paddr)
               APB_STATUS: state_next.prdata = {30'h0000_0000, state_reg.done, state_reg.st != HC_IDLE};
               APB_RDATA: state_next.prdata = {24'h00_0000, state_reg.rdata};
               default: state_next.pslverr = paddr != APB_CTRL;
            endcase
         end
      end
      unique case (state_reg.st)
         HC_IDLE: begin
            state_next.tsel_n = 1'b1;
            state_next.dsel_n = 1'b1;
            state_next.oe_n = 1'b1;
         end
         HC_SETUP: begin
            // Exactly one select goes low
            state_next.tsel_n = state_reg.dsp;
            state_next.dsel_n = !state_reg.dsp;
            state_next.oe_n = state_reg.rnw;
            state_next.wait_cnt = 8'h00;
            state_next.st = HC_WAIT;
         end
         HC_WAIT: begin
            state_next.wait_cnt = state_reg.wait_cnt + 8'h01;
            // DSP accesses end on acknowledge, timer accesses on a fixed wait
            if ((state_reg.dsp && ack_seen) || (!state_reg.dsp && state_reg.wait_cnt == TIMER_READ_WAIT)) begin
               if (state_reg.rnw) begin
                  state_next.rdata = port.dev_data_out;
               end
               state_next.st = HC_DONE;
            end
         end
         HC_DONE: begin
            state_next.tsel_n = 1'b1;
            state_next.dsel_n = 1'b1;
            state_next.oe_n = 1'b1;
            state_next.done = 1'b1;
            state_next.st = HC_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= '0;
         state_reg.st <= HC_IDLE;
         state_reg.tsel_n <= 1'b1;
         state_reg.dsel_n <= 1'b1;
         state_reg.oe_n <= 1'b1;
         state_reg.rnw <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from the state register
   assign prdata = state_reg.prdata;
   assign pready = state_reg.pready;
   assign pslverr = state_reg.pslverr;
   assign port.host_addr_bus = state_reg.addr;
   assign port.host_data_out = state_reg.wdata;
   assign port.host_data_oe_n = state_reg.oe_n;
   assign port.host_read_not_write = state_reg.rnw;
   assign port.timer_core_select_n = state_reg.tsel_n;
   assign port.dsp_core_select_n = state_reg.dsel_n;
endmodule : tchp_host
`default_nettype wire

// ===== tchp_properties.sv
// Checker of the parallel host port between host and device ends
`timescale 1ns/1ps
`default_nettype none
module tchp_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [6:0] host_addr_bus,
   input wire logic host_data_oe_n,
   input wire logic dev_data_oe_n,
   input wire logic host_read_not_write,
   input wire logic timer_core_select_n,
   input wire logic dsp_core_select_n,
   input wire logic transfer_ack_out_n,
   input wire logic transfer_ack_oe_n
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // DSP access steps: select falls, then acknowledge within a few edges
   sequence dsp_begin; $fell(dsp_core_select_n); endsequence
   sequence ack_given; ##[1:4] (!transfer_ack_out_n && !transfer_ack_oe_n); endsequence
   // Acknowledge ownership and timing
   a_timer_no_ack: assert property (!timer_core_select_n |-> transfer_ack_oe_n)
      else $error("ack driven in timer access");
   a_ack_in_dsp: assert property (!transfer_ack_oe_n |-> $past(!dsp_core_select_n))
      else $error("ack driven without DSP select");
   a_dsp_ack_delay: assert property (dsp_begin |-> ack_given)
      else $error("DSP access not acknowledged in time");
   a_ack_holds_low: assert property ((!transfer_ack_out_n && !dsp_core_select_n) |=>
      (!transfer_ack_out_n || dsp_core_select_n))
      else $error("ack released while selected");
   a_dsp_release_ack: assert property ($rose(dsp_core_select_n) |-> $past(!transfer_ack_out_n))
      else $error("DSP select released before ack");
   // Select and direction discipline
   a_one_select: assert property (!(!timer_core_select_n && !dsp_core_select_n))
      else $error("both selects low");
   a_write_drive: assert property (!host_data_oe_n |-> !host_read_not_write)
      else $error("host drives data during read");
   a_dev_read_drive: assert property (!dev_data_oe_n |-> $past(host_read_not_write))
      else $error("device drives data during write");
   a_no_clash: assert property (!(!host_data_oe_n && !dev_data_oe_n))
      else $error("both ends drive data");
   a_timer_hold: assert property ($fell(timer_core_select_n) |->
      (!timer_core_select_n) [*4] ##[1:6] timer_core_select_n)
      else $error("timer select held wrongly");
   a_addr_stable: assert property ((!timer_core_select_n && $past(!timer_core_select_n)) |->
      $stable(host_addr_bus) && $stable(host_read_not_write))
      else $error("address moved during select");
endmodule : tchp_properties
`default_nettype wire

// ===== test_timer_core_host_port.sv
// Testbench joining host and device ends of the parallel host port
`timescale 1ns/1ps
`default_nettype none
module test_timer_core_host_port;
   import tchp_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, dsps;
   logic [13:0] mc0, mc1;
   logic [23:0] rxw;
   logic [15:0] txw;
   logic [6:0] rxs;
   logic [10:0] txs;
   logic [12:0] mons;
   logic [9:0] key0, key1;
   logic [5:0] pwr;
   logic [31:0] dspr;
   int err_count = 0;
   int tests_run = 0;
   int strobe_count = 0;
   tchp_if tchp_if_inst ();
   tchp_device tchp_device_inst (.pclk(pclk), .presetn(presetn), .port(tchp_if_inst.device),
      .mode_control_0(mc0), .mode_control_1(mc1), .rx_window_len(rxw), .tx_window_len(txw),
      .rx_burst_start(rxs), .tx_burst_start(txs), .monitor_burst_start(mons), .tx_key_len_0(key0),
      .tx_key_len_1(key1), .power_on_1_lead(pwr), .dsp_regs(dspr), .dsp_write_strobe(dsps));
   tchp_host tchp_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .port(tchp_if_inst.host));
   tchp_properties tchp_properties_inst (.pclk(pclk), .presetn(presetn),
      .host_addr_bus(tchp_if_inst.host_addr_bus), .host_data_oe_n(tchp_if_inst.host_data_oe_n),
      .dev_data_oe_n(tchp_if_inst.dev_data_oe_n), .host_read_not_write(tchp_if_inst.host_read_not_write),
      .timer_core_select_n(tchp_if_inst.timer_core_select_n),
      .dsp_core_select_n(tchp_if_inst.dsp_core_select_n),
      .transfer_ack_out_n(tchp_if_inst.transfer_ack_out_n),
      .transfer_ack_oe_n(tchp_if_inst.transfer_ack_oe_n));
   // Clock of 8 ns
   initial begin
      forever #4 pclk = ~pclk;
   end
   // Count DSP write strobes
   always @(posedge pclk) begin
      if (dsps === 1'b1) begin
         strobe_count <= strobe_count + 1;
      end
   end
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Verdict and end of run
   task automatic final_report;
      $display("Checks %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : final_report
   // One APB transfer, held until pready is seen
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
      output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // One port access ordered through the controller, then status and read data
   task automatic op(input logic rnw, input logic dsp, input logic [6:0] a, input logic [7:0] d,
      output logic [7:0] q);
      logic [31:0] r;
      logic e;
      apb(1'b1, APB_CTRL, {8'h00, d, 1'b0, a, 5'h00, dsp, rnw, 1'b1}, r, e);
      while ((tchp_if_inst.timer_core_select_n & tchp_if_inst.dsp_core_select_n) !== 1'b0) @(posedge pclk);
      while ((tchp_if_inst.timer_core_select_n & tchp_if_inst.dsp_core_select_n) !== 1'b1) @(posedge pclk);
      apb(1'b0, APB_STATUS, 32'h0000_0000, r, e);
      chk(r[1], 1'b1);
      apb(1'b0, APB_RDATA, 32'h0000_0000, r, e);
      q = r[7:0];
   endtask : op
   // Every mapped timer byte, 00 to 12, written, then one byte alone
   task automatic t_write_map;
      logic [7:0] q;
      for (int o = 0; o <= 18; o++) op(1'b0, 1'b0, 7'(o), 8'(255 - o * 13), q);
      chk(mc0, 14'h3ff2);
      chk(mc1, 14'h25d8);
      chk(rxw, 24'hb1_becb);
      chk(txw, 16'h97a4);
      chk(rxs, 7'h0a);
      chk(txs, 11'h570);
      chk(mons, 13'h0356);
      chk(key0, 10'h13c);
      chk(key1, 10'h322);
      chk(pwr, 6'h15);
      op(1'b0, 1'b0, 7'h0a, 8'h02, q);
      chk(txs, 11'h270);
      $display("Test write map done");
   endtask : t_write_map
   // Read back, write-only and reserved places
   task automatic t_read_back;
      logic [7:0] q;
      op(1'b1, 1'b0, 7'h00, 8'h00, q);
      chk(q, 8'h3f);
      op(1'b1, 1'b0, 7'h01, 8'h00, q);
      chk(q, 8'hf2);
      op(1'b1, 1'b0, 7'h04, 8'h00, q);
      chk(q, 8'h00);
      op(1'b0, 1'b0, 7'h7f, 8'hff, q);
      op(1'b1, 1'b0, 7'h7f, 8'h00, q);
      chk(q, 8'h00);
      chk(mc0, 14'h3ff2);
      $display("Test read back done");
   endtask : t_read_back
   // DSP space with high address lines set
   task automatic t_dsp;
      logic [7:0] q;
      op(1'b0, 1'b1, 7'h7e, 8'h5a, q);
      chk(dspr[23:16], 8'h5a);
      chk(strobe_count, 32'h0000_0001);
      op(1'b0, 1'b1, 7'h41, 8'hc3, q);
      chk(dspr[15:8], 8'hc3);
      chk(strobe_count, 32'h0000_0002);
      op(1'b1, 1'b1, 7'h02, 8'h00, q);
      chk(q, 8'h5a);
      chk(strobe_count, 32'h0000_0002);
      chk(mc1, 14'h25d8);
      $display("Test DSP space done");
   endtask : t_dsp
   // Reset in mid-run clears the written registers
   task automatic t_reset;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(mc0, MODE_RESET);
      chk(txs, {BYTE_RESET[2:0], BYTE_RESET});
      chk(dspr, {4{BYTE_RESET}});
      $display("Test reset done");
   endtask : t_reset
   // Unmapped controller address refused
   task automatic t_apb;
      logic [31:0] r;
      logic e;
      apb(1'b0, 8'h0c, 32'h0000_0000, r, e);
      chk(e, 1'b1);
      apb(1'b1, 8'h0c, 32'h0000_0000, r, e);
      chk(e, 1'b1);
      apb(1'b0, APB_STATUS, 32'h0000_0000, r, e);
      chk(e, 1'b0);
      $display("Test APB map done");
   endtask : t_apb
   // Main sequence
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_write_map();
      t_read_back();
      t_dsp();
      t_reset();
      t_apb();
      final_report();
   end
   // Watchdog
   initial begin
      #40000;
      err_count++;
      $display("Error at %0t: watchdog expired", $time);
      final_report();
   end
endmodule : test_timer_core_host_port
`default_nettype wire
